/* base_field_reg.sv */
`timescale 1ns/1ps
// storage for the six writable base bits only
module base_field_reg (
    input  wire logic                           sys_clk,   // system clock
    input  wire logic                           rst_b,     // async reset, low
    input  wire logic                           wr_en,     // write this field
    input  wire logic [ram_part_pkg::FIELD_W-1:0] wr_data, // new field value
    output logic      [ram_part_pkg::FIELD_W-1:0] field_q  // stored field
);
    import ram_part_pkg::*;

    // field flops, cleared on reset
    // reset clears field
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            field_q <= FIELD_RST;
        end else if (wr_en) begin
            field_q <= wr_data;
        end
    end
endmodule // base_field_reg

/* ram_part_pkg.sv */
// Behaviour
// - upper sixteen bits read zero, no storage
// - six-bit writable base field, bits 15:10
// - low ten bits read zero, 1 KB steps
// - reset clears base, all RAM kernel
package ram_part_pkg;
    localparam int          ADDR_W        = 4;      // register address width
    localparam int          DATA_W        = 32;     // register data width
    localparam int          FIELD_W       = 6;      // user base field width
    localparam int          FIELD_LSB     = 10;     // field low bit position
    localparam int          FIELD_MSB     = 15;     // field high bit position
    localparam logic [3:0]  USER_BASE_OFS = 4'h0;   // user data base offset
    localparam logic [3:0]  STATUS_OFS    = 4'h4;   // consistency status offset
    localparam logic [5:0]  FIELD_RST     = 6'h00;  // field reset value
    localparam logic [31:0] READ_ZERO     = 32'h00000000; // unmapped read value
    localparam int          ST_NONZERO    = 0;      // status bit: user region exists
    localparam int          ST_ABOVE_KPB  = 1;      // status bit: base above kernel base
    localparam int          ST_WITHIN_RAM = 2;      // status bit: base within ram size
endpackage

/* ram_user_data_partition.sv */
`timescale 1ns/1ps
module ram_user_data_partition (
    input  wire logic                              sys_clk,             // system clock
    input  wire logic                              rst_b,               // async reset, low
    input  wire logic [ram_part_pkg::ADDR_W-1:0]   reg_addr,            // register address
    input  wire logic [ram_part_pkg::DATA_W-1:0]   reg_wdata,           // write data
    input  wire logic                              reg_wr,              // write strobe
    input  wire logic                              reg_rd,              // read strobe
    output logic      [ram_part_pkg::DATA_W-1:0]   reg_rdata,           // read data, next cycle
    input  wire logic [ram_part_pkg::DATA_W-1:0]   kernel_program_base, // kernel program base
    input  wire logic [ram_part_pkg::DATA_W-1:0]   ram_size_value,      // ram size value
    output logic      [ram_part_pkg::DATA_W-1:0]   ram_user_data_base   // base to partition logic
);
    import ram_part_pkg::*;

    // field storage and its image
    logic [FIELD_W-1:0] field_q;      // stored six-bit field
    logic               field_wr;     // write hits user base
    logic [DATA_W-1:0]  base_word;    // full register image
    // read side
    logic [DATA_W-1:0]  status_word;  // consistency flags
    logic [DATA_W-1:0]  rdata_next;   // read mux
    // consistency flags, reported only
    logic               nonzero;      // user region present
    logic               above_kpb;    // base above kernel base
    logic               within_ram;   // base within ram size
    // decode helpers for the checks and covers
    logic               base_rd;      // read of the base register
    logic               status_rd;    // read of the status word
    logic               other_rd;     // read of an unmapped offset
    logic               other_wr;     // write that misses the field

    // only the field bits of the write data are taken
    // a write to any other offset, status included, lands nowhere
    assign field_wr = reg_wr && (reg_addr == USER_BASE_OFS);

    // decode helpers, read only by the checks and covers below
    assign base_rd   = reg_rd && (reg_addr == USER_BASE_OFS);
    assign status_rd = reg_rd && (reg_addr == STATUS_OFS);
    assign other_rd  = reg_rd && (reg_addr != USER_BASE_OFS) && (reg_addr != STATUS_OFS);
    assign other_wr  = reg_wr && !field_wr;

    // six flops only; the rest of the register has no storage
    // writable field storage
    base_field_reg u_field (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .wr_en   (field_wr),
        .wr_data (reg_wdata[FIELD_MSB:FIELD_LSB]),
        .field_q (field_q)
    );

    // image: upper and low bits are constant zero, no flops
    // zero low bits keep the boundary on 1 KB steps
    // fixed zero bits
    always_comb begin
        base_word                      = READ_ZERO;
        base_word[FIELD_MSB:FIELD_LSB] = field_q;
    end
    assign ram_user_data_base = base_word;

    // software-facing checks; hardware does not enforce, only reports
    // a zero base means no user region, flags then mean little
    // unsigned compares over the full word, no wrap handling
    // consistency status
    assign nonzero    = (field_q != FIELD_RST);
    assign above_kpb  = base_word > kernel_program_base;
    assign within_ram = base_word <= ram_size_value;
    // flags packed into the low bits of the status word
    always_comb begin
        status_word                = READ_ZERO;
        status_word[ST_NONZERO]    = nonzero;
        status_word[ST_ABOVE_KPB]  = above_kpb;
        status_word[ST_WITHIN_RAM] = within_ram;
    end

    // read decode, unmapped reads give zero
    // zero outside a read keeps the data port quiet between reads
    always_comb begin
        rdata_next = READ_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                USER_BASE_OFS: rdata_next = base_word;   // base register
                STATUS_OFS:    rdata_next = status_word; // status
                default:       rdata_next = READ_ZERO;   // unmapped
            endcase
        end
    end

    // read data stands one cycle after the strobe only
    // registered so the answer never races the strobe that asked
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= READ_ZERO;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // checks on the register image and the read port, one clock domain;
    // all but the two reset checks sleep while reset is held low

    // upper half never nonzero
    // no flops there, so this guards later edits of the image
    chk_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ram_user_data_base[DATA_W-1:FIELD_MSB+1] == READ_ZERO[DATA_W-1:FIELD_MSB+1])
        else $error("upper bits nonzero");

    // low ten bits never nonzero
    // keeps the user boundary on whole 1 KB steps
    chk_low_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ram_user_data_base[FIELD_LSB-1:0] == READ_ZERO[FIELD_LSB-1:0])
        else $error("low bits nonzero");

    // write lands field next cycle
    // the partition logic sees the new boundary one cycle on
    chk_field_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        field_wr |=> ram_user_data_base[FIELD_MSB:FIELD_LSB]
                     == $past(reg_wdata[FIELD_MSB:FIELD_LSB]))
        else $error("field write lost");

    // field holds without a write
    // no path but the strobe may touch the flops
    chk_field_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !field_wr |=> $stable(ram_user_data_base))
        else $error("field changed");

    // read returns register image next cycle
    // a field write in the same cycle is excluded, so the image is settled here
    chk_read_base: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == USER_BASE_OFS && !field_wr)
        |=> reg_rdata == ram_user_data_base)
        else $error("read mismatch");

    // no read, zero data
    // a quiet port makes stale data easy to spot
    chk_idle_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !reg_rd |=> reg_rdata == READ_ZERO)
        else $error("stray read data");

    // reset value zero
    // the whole ram belongs to kernel data after any reset
    chk_reset_zero: assert property (@(posedge sys_clk)
        $rose(rst_b) |-> ram_user_data_base == READ_ZERO)
        else $error("reset not zero");

    // read data also cleared by reset
    // no leftover word may leak out after a reset
    chk_reset_rdata: assert property (@(posedge sys_clk)
        $rose(rst_b) |-> reg_rdata == READ_ZERO)
        else $error("read data not cleared");

    // status tracks kernel comparison
    // reported only, software keeps the ordering
    chk_status_kpb: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == STATUS_OFS) |=>
        reg_rdata[ST_ABOVE_KPB] == $past(above_kpb))
        else $error("status wrong");

    // status tracks ram size comparison
    // reported only, software keeps the base within ram
    chk_status_ram: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (reg_rd && reg_addr == STATUS_OFS) |=>
        reg_rdata[ST_WITHIN_RAM] == $past(within_ram))
        else $error("status wrong");

    // status flag for a present user region, seen from the ports
    chk_status_nonzero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        status_rd |=>
        reg_rdata[ST_NONZERO] == ($past(ram_user_data_base) != READ_ZERO))
        else $error("status nonzero flag wrong");

    // status bits above the flags read zero
    // room left for more flags without moving these
    chk_status_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
        status_rd |=>
        reg_rdata[DATA_W-1:ST_WITHIN_RAM+1] == READ_ZERO[DATA_W-1:ST_WITHIN_RAM+1])
        else $error("status high bits nonzero");

    // base read: upper half of the data zero
    // seen at the port, not only at the image
    chk_read_upper: assert property (@(posedge sys_clk) disable iff (!rst_b)
        base_rd |=>
        reg_rdata[DATA_W-1:FIELD_MSB+1] == READ_ZERO[DATA_W-1:FIELD_MSB+1])
        else $error("read upper bits nonzero");

    // base read: low ten bits of the data zero
    // seen at the port, not only at the image
    chk_read_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
        base_rd |=>
        reg_rdata[FIELD_LSB-1:0] == READ_ZERO[FIELD_LSB-1:0])
        else $error("read low bits nonzero");

    // write then read back to back returns the new field
    // catches a read mux that lags the flops by a cycle
    chk_write_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
        field_wr ##1 base_rd |=>
        reg_rdata[FIELD_MSB:FIELD_LSB] == $past(reg_wdata[FIELD_MSB:FIELD_LSB], 2))
        else $error("readback after write wrong");

    // unmapped offsets read zero
    // software probing the map sees no ghost registers
    chk_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!rst_b)
        other_rd |=> reg_rdata == READ_ZERO)
        else $error("unmapped read nonzero");

    // writes to the status word or unmapped offsets change nothing
    // the status word is read only, a write there is dropped
    chk_stray_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
        other_wr |=> $stable(ram_user_data_base))
        else $error("stray write moved base");

    // covers for the main scenarios
    // a field write
    cov_write: cover property (@(posedge sys_clk) disable iff (!rst_b) field_wr);
    // a user region present
    cov_nonzero: cover property (@(posedge sys_clk) disable iff (!rst_b) nonzero);
    // a base read
    cov_read: cover property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd && reg_addr == USER_BASE_OFS);
    // a status read
    cov_status: cover property (@(posedge sys_clk) disable iff (!rst_b) status_rd);
    // a base not above the kernel base, flagged only
    cov_violation: cover property (@(posedge sys_clk) disable iff (!rst_b)
        nonzero && !above_kpb);

endmodule // ram_user_data_partition

/* ram_user_data_partition_tb.sv */
`timescale 1ns/1ps
module ram_user_data_partition_tb;
    import ram_part_pkg::*;
    logic        sys_clk             = 1'b0;          // 10 MHz bench clock
    logic        rst_b               = 1'b0;          // async reset, low
    logic [3:0]  reg_addr            = 4'h0;          // register address
    logic [31:0] reg_wdata           = 32'h00000000;  // write data
    logic        reg_wr              = 1'b0;          // write strobe
    logic        reg_rd              = 1'b0;          // read strobe
    logic [31:0] kernel_program_base = 32'h00000000;  // kernel base level
    logic [31:0] ram_size_value      = 32'h00000000;  // ram size level
    logic [31:0] reg_rdata;                           // read data
    logic [31:0] ram_user_data_base;                  // base output
    logic        rd_q                = 1'b0;          // read taken last edge
    logic [31:0] exp_q[$];                            // expected read data
    int          miscompares         = 0;             // failed checks
    int          checks              = 0;             // all checks
    ram_user_data_partition ram_user_data_partition_inst (.sys_clk(sys_clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .kernel_program_base(kernel_program_base),
        .ram_size_value(ram_size_value), .ram_user_data_base(ram_user_data_base));
    // free-running clock, half period 50 ns
    always #50 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one-cycle strobes, back to back allowed
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk); reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_rd <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk); reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0; exp_q.push_back(e);
    endtask
    task automatic idle;
        @(posedge sys_clk); reg_wr <= 1'b0; reg_rd <= 1'b0;
    endtask
    // status word worked out from the levels, unsigned compares
    function automatic logic [31:0] stat(input logic [31:0] b, k, r);
        return {29'h0, b <= r, b > k, b != 32'h0};
    endfunction
    // watcher: data stand only in the cycle after the read strobe
    always @(posedge sys_clk) begin
        rd_q <= reg_rd;
        if (rd_q) begin
            if (exp_q.size() == 0) chk("unexpected read", 32'h1, 32'h0);
            else chk("read data", reg_rdata, exp_q.pop_front()); // read word
        end
    end
    // bounded run, a hang counts as a failure
    initial begin
        repeat (3000) @(posedge sys_clk);
        miscompares++;
        test_done;
    end
    initial begin
        logic [31:0] d, b, k, r;
        void'($urandom(32'h8AD1));
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(USER_BASE_OFS, 32'h00000000); // cleared at reset
        idle; @(negedge sys_clk); chk("base after reset", ram_user_data_base, 32'h0);
        $display("test reset done");
        // all-ones, zero field with low bits set, then random words
        // the levels break the ordering on purpose to drive the flags
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h000003FF : $urandom;
            b = d & 32'h0000FC00;
            k = i[1] ? b : ($urandom & 32'h0000FFFF);
            r = i[0] ? b : ($urandom & 32'h0000FFFF);
            @(posedge sys_clk); kernel_program_base <= k; ram_size_value <= r;
            wr(USER_BASE_OFS, d);
            rd(USER_BASE_OFS, b); // field kept, low bits zero
            rd(STATUS_OFS, stat(b, k, r)); // flags worked out from base and levels
            wr(STATUS_OFS, 32'hFFFFFFFF); // read-only place ignored
            wr(4'h8, 32'h0000FC00);
            rd(4'h8, 32'h00000000); // unmapped reads zero
            rd(USER_BASE_OFS, b); // stray writes left base alone
            idle; @(negedge sys_clk); chk("base output", ram_user_data_base, b);
        end
        $display("test field writes done");
        // software keeps the ordering: kernel base below, ram size above
        @(posedge sys_clk);
        kernel_program_base <= 32'h00000800; // kept below the base
        ram_size_value      <= 32'h00003000; // kept above the base
        wr(USER_BASE_OFS, 32'h00002000);
        rd(STATUS_OFS, 32'h00000007); // all flags set
        idle;
        $display("test legal layout done");
        // second reset in mid-run clears the stored field
        wr(USER_BASE_OFS, 32'h00008400);
        idle;
        @(negedge sys_clk);
        chk("base before reset", ram_user_data_base, 32'h00008400);
        idle;
        rst_b <= 1'b0; @(posedge sys_clk); rst_b <= 1'b1;
        @(negedge sys_clk); chk("base mid reset", ram_user_data_base, 32'h0);
        rd(USER_BASE_OFS, 32'h00000000); // register reads zero
        idle;
        for (int n = 0; n < 8 && exp_q.size() != 0; n++) @(posedge sys_clk);
        if (exp_q.size() != 0) miscompares++;
        $display("test mid reset done");
        test_done;
    end
endmodule // ram_user_data_partition_tb
